// ===== rtl/tlb_fault_pkg.sv
// Package with constants and types for the translation-fault and mode logic.
package tlb_fault_pkg;
   localparam int          VADDR_W        = 32;
   localparam int          ASID_W         = 8;
   localparam int          VPN2_W         = 19;
   localparam int          VPN2_LSB       = 13;
   localparam int          ENTRIES        = 64;
   localparam int          IDX_W          = 6;
   localparam logic [1:0]  PRIV_KERNEL    = 2'h0;
   localparam logic [1:0]  PRIV_SUPER     = 2'h1;
   localparam logic [1:0]  PRIV_USER      = 2'h2;
   localparam logic [31:0] USER_TOP       = 32'h8000_0000;
   localparam logic [31:0] SUPER_LO       = 32'hc000_0000;
   localparam logic [31:0] SUPER_HI       = 32'hdfff_ffff;
   localparam logic [31:0] XSEG_TOP_LEG   = 32'h8000_0000;
   localparam logic [31:0] XSEG_TOP_MAX   = 32'hc000_0000;
   localparam logic [4:0]  PTR_LSB_RST    = 5'h04;
   localparam logic [4:0]  PTR_LEN_RST    = 5'h13;
   localparam logic [31:0] PTR_RST        = 32'h0000_0000;
   localparam logic [31:0] VADDR_RST      = 32'h0000_0000;

   // Addressing modes.
   typedef enum logic [1:0] {
      MODE_USER,
      MODE_SUPER,
      MODE_KERNEL,
      MODE_DEBUG
   } addr_mode_t;

   // Fault codes reported for one access.
   typedef enum logic [2:0] {
      FAULT_NONE,
      FAULT_LOAD_ADDR,
      FAULT_STORE_ADDR,
      FAULT_REFILL,
      FAULT_LOAD_INVALID,
      FAULT_STORE_INVALID,
      FAULT_MODIFIED
   } fault_t;
endpackage : tlb_fault_pkg

// ===== rtl/tlb_fault_and_mode_logic.sv
// Fault classification, fault registers, duplicate purge and addressing-mode decode.
//
// Overview of operation
// RULE1: User or supervisor load to a forbidden address raises the load address error.
// RULE2: User or supervisor store to a forbidden address raises the store address error.
// RULE3: A lookup with no matching entry raises the refill fault in every mode.
// RULE4: A non-store hit on an invalid entry raises the load invalid-entry fault.
// RULE5: A store hit on an invalid entry raises the store invalid-entry fault.
// RULE6: A store hit on an entry without write permission raises the page-modified fault.
// RULE7: Layout config places the faulting page field in the pointer; other bits stay software.
// RULE8: Faulting address register is read-only, 32 bits, holding the latest faulting address.
// RULE9: Cache and bus errors never update the faulting address register.
// RULE10: A translation fault writes the missing page number into the entry-high register.
// RULE11: A write matching existing entries invalidates the older ones without a machine check.
// RULE12: Every entry write searches all array entries for duplicates.
// RULE13: Boot software must initialise every entry before translation is relied on.
// RULE14: Exception and error levels clear, privilege 2, debug clear selects user mode.
// RULE15: Exception and error levels clear, privilege 1, debug clear selects supervisor mode.
// RULE16: Privilege 0 or error or exception level selects kernel; debug flag selects debug.
// RULE17: Exception level set without debug sends a miss to the general handler.
// RULE18: Supervisor mode exists only in the translation-buffer configuration.
// RULE19: User-style load and store let kernel code make mapped user-segment accesses.
// RULE20: Extended address scheme is present only in translation-buffer configurations.
// RULE21: Kernel unmapped segment may reach 3.0 GB, keeping a mapped kernel segment.
// RULE22: A clear write-permitted flag faults stores; a set flag allows them.
// RULE23: A clear valid flag faults any access; a set flag permits it.
// RULE24: Only one fault is reported, address errors taking precedence over translation faults.
`timescale 1ns/1ps
module tlb_fault_and_mode_logic
   import tlb_fault_pkg::*;
#(
   parameter bit HAS_TLB = 1'b1
)(
   input  wire logic              clk_i,
   input  wire logic              sys_rst_i,
   // Status bits that select the addressing mode.
   input  wire logic              exception_level_bit_i,
   input  wire logic              error_level_bit_i,
   input  wire logic [1:0]        privilege_field_i,
   input  wire logic              debug_flag_i,
   input  wire logic              extended_address_scheme_en_i,
   input  wire logic              user_style_access_i,
   // Access request from the pipeline.
   input  wire logic              acc_valid_i,
   input  wire logic              acc_store_i,
   input  wire logic [31:0]       acc_vaddr_i,
   input  wire logic              cache_or_bus_error_i,
   // Entry write from the pipeline.
   input  wire logic              ent_wr_i,
   input  wire logic [IDX_W-1:0]  ent_wr_idx_i,
   input  wire logic [VPN2_W-1:0] ent_wr_vpn2_i,
   input  wire logic [ASID_W-1:0] ent_wr_asid_i,
   input  wire logic              ent_wr_global_i,
   input  wire logic              ent_wr_valid0_i,
   input  wire logic              ent_wr_valid1_i,
   input  wire logic              ent_wr_dirty0_i,
   input  wire logic              ent_wr_dirty1_i,
   input  wire logic [ASID_W-1:0] cur_asid_i,
   // Software writes to the pointer and its layout config.
   input  wire logic              ptr_wr_i,
   input  wire logic [31:0]       ptr_wdata_i,
   input  wire logic              layout_wr_i,
   input  wire logic [4:0]        layout_lsb_i,
   input  wire logic [4:0]        layout_len_i,
   // Results.
   output addr_mode_t             addr_mode_o,
   output logic                   fault_valid_o,
   output fault_t                 fault_code_o,
   output logic                   general_vector_o,
   output logic                   ext_kernel_seg_o,
   output logic [31:0]            page_table_pointer_o,
   output logic [31:0]            faulting_virtual_address_o,
   output logic [VPN2_W-1:0]      entry_high_vpn2_o,
   output logic [ENTRIES-1:0]     dup_purged_o
);

   // Translation array tags and flags.
   logic [VPN2_W-1:0] tag_vpn2_ff   [ENTRIES];
   logic [ASID_W-1:0] tag_asid_ff   [ENTRIES];
   logic              tag_global_ff [ENTRIES];
   logic [1:0]        ent_valid_ff  [ENTRIES];
   logic [1:0]        ent_dirty_ff  [ENTRIES];

   logic [31:0]       layout_mask_ff;
   logic [4:0]        layout_lsb_ff;
   logic [31:0]       ptr_ff;
   logic [31:0]       vaddr_ff;
   logic [VPN2_W-1:0] ehi_vpn2_ff;
   logic              fault_valid_ff;
   fault_t            fault_code_ff;
   logic              gen_vec_ff;
   logic [ENTRIES-1:0] purge_ff;

   addr_mode_t        mode;
   addr_mode_t        eff_mode;
   logic              hit;
   logic [IDX_W-1:0]  hit_idx;
   logic              addr_bad;
   logic              sel_odd;
   fault_t            nxt_fault;
   logic [31:0]       nxt_mask;
   logic [31:0]       nxt_ptr_vpn;
   logic [VPN2_W-1:0] acc_vpn2;

   assign acc_vpn2 = acc_vaddr_i[VADDR_W-1:VPN2_LSB];
   assign sel_odd  = acc_vaddr_i[VPN2_LSB-1];

   // Mode decode; debug overrides all, then kernel conditions, then user and supervisor.
   always_comb begin
      if (debug_flag_i) begin
         mode = MODE_DEBUG;                                                   // [RULE16]
      end else if (exception_level_bit_i || error_level_bit_i || privilege_field_i == PRIV_KERNEL) begin
         mode = MODE_KERNEL;                                                  // [RULE16]
      end else if (privilege_field_i == PRIV_USER) begin
         mode = MODE_USER;                                                    // [RULE14]
      end else if (privilege_field_i == PRIV_SUPER && HAS_TLB) begin
         mode = MODE_SUPER;                                                   // [RULE15] [RULE18]
      end else begin
         // Without the translation buffer the supervisor code falls back to user rights.
         mode = MODE_USER;                                                    // [RULE18]
      end
   end
   assign addr_mode_o = mode;

   // Kernel code issuing user-style accesses is checked and translated as user when the extended scheme is built and enabled.
   always_comb begin
      if (user_style_access_i && mode == MODE_KERNEL && HAS_TLB && extended_address_scheme_en_i) begin
         eff_mode = MODE_USER;                                                // [RULE19] [RULE20]
      end else begin
         eff_mode = mode;
      end
   end

   // Extended kernel segment spans up to 3.0 GB only when the scheme is built and enabled.
   assign ext_kernel_seg_o = HAS_TLB && extended_address_scheme_en_i;   // [RULE20] [RULE21]

   // Privilege check: user sees the low segment (up to 3.0 GB when extended); supervisor adds its window.
   always_comb begin
      logic [31:0] utop;
      utop = ext_kernel_seg_o ? XSEG_TOP_MAX : USER_TOP;                      // [RULE21]
      addr_bad = 1'b0;
      if (eff_mode == MODE_USER) begin
         addr_bad = (acc_vaddr_i >= utop);
      end else if (eff_mode == MODE_SUPER) begin
         addr_bad = (acc_vaddr_i >= utop) && !(acc_vaddr_i >= SUPER_LO && acc_vaddr_i <= SUPER_HI);
      end
   end

   // Associative lookup over every entry, honouring the global flag.
   always_comb begin
      hit     = 1'b0;
      hit_idx = '0;
      for (int i = 0; i < ENTRIES; i++) begin
         if (!hit && tag_vpn2_ff[i] == acc_vpn2 && (tag_global_ff[i] || tag_asid_ff[i] == cur_asid_i)) begin
            hit     = 1'b1;
            hit_idx = IDX_W'(i);
         end
      end
   end

   // One fault per access, address errors first, then miss, invalid, modified.
   always_comb begin
      nxt_fault = FAULT_NONE;
      if (addr_bad) begin
         nxt_fault = acc_store_i ? FAULT_STORE_ADDR : FAULT_LOAD_ADDR;       // [RULE1] [RULE2] [RULE24]
      end else if (!hit) begin
         nxt_fault = FAULT_REFILL;                                            // [RULE3]
      end else if (!ent_valid_ff[hit_idx][sel_odd]) begin
         nxt_fault = acc_store_i ? FAULT_STORE_INVALID : FAULT_LOAD_INVALID;  // [RULE4] [RULE5] [RULE23]
      end else if (acc_store_i && !ent_dirty_ff[hit_idx][sel_odd]) begin
         nxt_fault = FAULT_MODIFIED;                                          // [RULE6] [RULE22]
      end
   end

   // Fault result registers, one cycle after the access.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         fault_valid_ff <= 1'b0;
         fault_code_ff  <= FAULT_NONE;
         gen_vec_ff     <= 1'b0;
      end else begin
         fault_valid_ff <= acc_valid_i && nxt_fault != FAULT_NONE;
         fault_code_ff  <= acc_valid_i ? nxt_fault : FAULT_NONE;
         // A miss at exception level bypasses the refill handler.
         gen_vec_ff     <= acc_valid_i && nxt_fault == FAULT_REFILL && exception_level_bit_i && !debug_flag_i; // [RULE17]
      end
   end

   // Faulting address and entry-high page field; cache and bus errors leave them alone.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         vaddr_ff    <= VADDR_RST;
         ehi_vpn2_ff <= '0;
      end else if (acc_valid_i && nxt_fault != FAULT_NONE && !cache_or_bus_error_i) begin // [RULE9]
         vaddr_ff <= acc_vaddr_i;                                             // [RULE8]
         if (nxt_fault != FAULT_LOAD_ADDR && nxt_fault != FAULT_STORE_ADDR) begin
            ehi_vpn2_ff <= acc_vpn2;                                          // [RULE10]
         end
      end
   end

   // Layout config: mask of the faulting-page field within the pointer.
   always_comb begin
      nxt_mask = '0;
      for (int b = 0; b < 32; b++) begin
         if (b >= int'(layout_lsb_i) && b < int'(layout_lsb_i) + int'(layout_len_i)) begin
            nxt_mask[b] = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         layout_lsb_ff  <= PTR_LSB_RST;
         layout_mask_ff <= 32'h007f_fff0;
      end else if (layout_wr_i) begin
         layout_lsb_ff  <= layout_lsb_i;                                      // [RULE7]
         layout_mask_ff <= nxt_mask;
      end
   end

   // Faulting page bits shifted into the selected field; the field wins over a same-cycle write.
   assign nxt_ptr_vpn = (32'(acc_vpn2) << layout_lsb_ff) & layout_mask_ff;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ptr_ff <= PTR_RST;
      end else begin
         // Software owns only the base bits; the faulting page field keeps what hardware last wrote.
         if (ptr_wr_i) begin
            ptr_ff <= (ptr_wdata_i & ~layout_mask_ff) | (ptr_ff & layout_mask_ff); // [RULE7]
         end
         if (acc_valid_i && nxt_fault != FAULT_NONE && nxt_fault != FAULT_LOAD_ADDR &&
             nxt_fault != FAULT_STORE_ADDR && !cache_or_bus_error_i) begin
            ptr_ff <= ((ptr_wr_i ? ptr_wdata_i : ptr_ff) & ~layout_mask_ff) | nxt_ptr_vpn; // [RULE7]
         end
      end
   end

   // Entry write: search every entry, clear older duplicates, store the new one.
   // Contents are not cleared at reset; boot code must fill the whole array first.
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         purge_ff <= '0;
      end else if (ent_wr_i) begin
         for (int i = 0; i < ENTRIES; i++) begin
            purge_ff[i] <= (i != int'(ent_wr_idx_i)) && tag_vpn2_ff[i] == ent_wr_vpn2_i &&
                           (tag_global_ff[i] || ent_wr_global_i || tag_asid_ff[i] == ent_wr_asid_i); // [RULE12]
         end
      end else begin
         purge_ff <= '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ent_wr_i) begin
         for (int i = 0; i < ENTRIES; i++) begin
            if (i == int'(ent_wr_idx_i)) begin
               tag_vpn2_ff[i]   <= ent_wr_vpn2_i;
               tag_asid_ff[i]   <= ent_wr_asid_i;
               tag_global_ff[i] <= ent_wr_global_i;
               ent_valid_ff[i]  <= {ent_wr_valid1_i, ent_wr_valid0_i};
               ent_dirty_ff[i]  <= {ent_wr_dirty1_i, ent_wr_dirty0_i};
            end else if (tag_vpn2_ff[i] == ent_wr_vpn2_i &&
                         (tag_global_ff[i] || ent_wr_global_i || tag_asid_ff[i] == ent_wr_asid_i)) begin
               // Older duplicate is invalidated silently, no machine check.
               tag_vpn2_ff[i]  <= ~ent_wr_vpn2_i;                             // [RULE11] [RULE13]
               ent_valid_ff[i] <= 2'h0;                                       // [RULE11]
            end
         end
      end
   end

   assign fault_valid_o              = fault_valid_ff;
   assign fault_code_o               = fault_code_ff;
   assign general_vector_o           = gen_vec_ff;
   assign page_table_pointer_o       = ptr_ff;
   assign faulting_virtual_address_o = vaddr_ff;
   assign entry_high_vpn2_o          = ehi_vpn2_ff;
   assign dup_purged_o               = purge_ff;

endmodule : tlb_fault_and_mode_logic

// ===== bench/tlb_fault_and_mode_logic_properties.sv
// Port-level assertions for the fault and mode block.
`timescale 1ns/1ps
module tlb_fault_checker
   import tlb_fault_pkg::*;
(
   input logic               clk_i,
   input logic               sys_rst_i,
   input logic               exception_level_bit_i,
   input logic               error_level_bit_i,
   input logic [1:0]         privilege_field_i,
   input logic               debug_flag_i,
   input logic               user_style_access_i,
   input logic               acc_valid_i,
   input logic               acc_store_i,
   input logic [31:0]        acc_vaddr_i,
   input logic               cache_or_bus_error_i,
   input logic               ent_wr_i,
   input addr_mode_t         addr_mode_o,
   input logic               fault_valid_o,
   input fault_t             fault_code_o,
   input logic               general_vector_o,
   input logic [31:0]        faulting_virtual_address_o,
   input logic [VPN2_W-1:0]  entry_high_vpn2_o,
   input logic [ENTRIES-1:0] dup_purged_o
);
   // Page number of the current access, kept as a signal so that its past value can be taken.
   logic [VPN2_W-1:0] vpn_now;
   assign vpn_now = acc_vaddr_i[31:VPN2_LSB];

   // One clock domain, so one clocking and one reset serve every property.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // Addresses at or above this top are forbidden to user code in either address map.
   property p_user_load;
      acc_valid_i && !acc_store_i && addr_mode_o == MODE_USER && acc_vaddr_i >= XSEG_TOP_MAX
         |=> fault_code_o == FAULT_LOAD_ADDR;
   endproperty
   a_user_load: assert property (p_user_load) else $error("user load above top not refused");
   property p_user_store;
      acc_valid_i && acc_store_i && addr_mode_o == MODE_USER && acc_vaddr_i >= XSEG_TOP_MAX
         |=> fault_code_o == FAULT_STORE_ADDR;
   endproperty
   a_user_store: assert property (p_user_store) else $error("user store above top not refused");
   property p_kernel_free;
      acc_valid_i && addr_mode_o == MODE_KERNEL && !user_style_access_i
         |=> !(fault_code_o inside {FAULT_LOAD_ADDR, FAULT_STORE_ADDR});
   endproperty
   a_kernel_free: assert property (p_kernel_free) else $error("kernel access got address error");
   property p_mode_user;
      !exception_level_bit_i && !error_level_bit_i && privilege_field_i == PRIV_USER && !debug_flag_i
         |-> addr_mode_o == MODE_USER;
   endproperty
   a_mode_user: assert property (p_mode_user) else $error("user mode not selected");
   property p_mode_super;
      !exception_level_bit_i && !error_level_bit_i && privilege_field_i == PRIV_SUPER && !debug_flag_i
         |-> addr_mode_o == MODE_SUPER;
   endproperty
   a_mode_super: assert property (p_mode_super) else $error("supervisor mode not selected");
   property p_mode_debug;
      debug_flag_i |-> addr_mode_o == MODE_DEBUG;
   endproperty
   a_mode_debug: assert property (p_mode_debug) else $error("debug mode not selected");
   property p_general;
      general_vector_o |-> fault_code_o == FAULT_REFILL && $past(exception_level_bit_i) && !$past(debug_flag_i);
   endproperty
   a_general: assert property (p_general) else $error("general vector without cause");
   property p_err_hold;
      acc_valid_i && cache_or_bus_error_i |=> $stable(faulting_virtual_address_o);
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("bus error moved fault address");
   property p_vaddr_src;
      $changed(faulting_virtual_address_o) && !$past(sys_rst_i)
         |-> fault_valid_o && faulting_virtual_address_o == $past(acc_vaddr_i);
   endproperty
   a_vaddr_src: assert property (p_vaddr_src) else $error("fault address changed without fault");
   property p_page_src;
      fault_valid_o && !$past(cache_or_bus_error_i) && fault_code_o inside
         {FAULT_REFILL, FAULT_LOAD_INVALID, FAULT_STORE_INVALID, FAULT_MODIFIED} |-> entry_high_vpn2_o == $past(vpn_now);
   endproperty
   a_page_src: assert property (p_page_src) else $error("entry high page wrong");
   property p_purge_src;
      |dup_purged_o |-> $past(ent_wr_i);
   endproperty
   a_purge_src: assert property (p_purge_src) else $error("purge without entry write");
endmodule : tlb_fault_checker

// ===== bench/pipeline_model.sv
// Behavioural pipeline issuing accesses and entry writes to the block.
`timescale 1ns/1ps
module pipeline_model
   import tlb_fault_pkg::*;
(
   input  wire logic         clk_i,
   output logic              acc_valid_o,
   output logic              acc_store_o,
   output logic [31:0]       acc_vaddr_o,
   output logic              ent_wr_o,
   output logic [IDX_W-1:0]  ent_idx_o,
   output logic [VPN2_W-1:0] ent_vpn2_o,
   output logic [3:0]        ent_flags_o
);
   // Idle from time zero so nothing is taken during reset.
   initial begin
      {acc_valid_o, acc_store_o, acc_vaddr_o, ent_wr_o, ent_idx_o, ent_vpn2_o, ent_flags_o} = '0;
   end

   // One access held over its edge; the address is scrambled once released so no stale value lingers.
   task automatic access(input logic st, input logic [31:0] a);
      @(posedge clk_i);
      #1;
      acc_valid_o = 1'b1;
      acc_store_o = st;
      acc_vaddr_o = a;
      @(posedge clk_i);
      #1;
      acc_valid_o = 1'b0;
      acc_vaddr_o = ~a;
   endtask : access

   // One entry write; flags are dirty1, dirty0, valid1, valid0 from the top.
   task automatic write_entry(input logic [IDX_W-1:0] i, input logic [VPN2_W-1:0] v, input logic [3:0] f);
      @(posedge clk_i);
      #1;
      ent_wr_o = 1'b1;
      ent_idx_o = i;
      ent_vpn2_o = v;
      ent_flags_o = f;
      @(posedge clk_i);
      #1;
      ent_wr_o = 1'b0;
      ent_vpn2_o = ~v;
   endtask : write_entry

   // The array wakes undefined, so every entry gets a distinct tag that no test address hits.
   task automatic boot_fill();
      for (int i = 0; i < ENTRIES; i++) begin
         write_entry(IDX_W'(i), {13'h1fff, IDX_W'(i)}, 4'h0);
      end
   endtask : boot_fill
endmodule : pipeline_model

// ===== bench/tlb_fault_and_mode_logic_tb_top.sv
// Self-checking bench for the fault and mode block.
`timescale 1ns/1ps
module tlb_fault_and_mode_logic_tb_top;
   import tlb_fault_pkg::*;
   logic clk_i, sys_rst_i, exception_level_bit_i, error_level_bit_i, debug_flag_i, user_style_access_i;
   logic extended_address_scheme_en_i, acc_valid_i, acc_store_i, cache_or_bus_error_i, ent_wr_i;
   logic ent_wr_global_i, ptr_wr_i, layout_wr_i, fault_valid_o, general_vector_o, ext_kernel_seg_o;
   logic [1:0] privilege_field_i;
   logic [3:0] fl;
   logic [4:0] layout_lsb_i, layout_len_i;
   logic [31:0] acc_vaddr_i, ptr_wdata_i, page_table_pointer_o, faulting_virtual_address_o;
   logic [IDX_W-1:0] ent_wr_idx_i;
   logic [VPN2_W-1:0] ent_wr_vpn2_i, entry_high_vpn2_o;
   logic [ASID_W-1:0] ent_wr_asid_i, cur_asid_i;
   logic [ENTRIES-1:0] dup_purged_o;
   addr_mode_t addr_mode_o;
   fault_t fault_code_o;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   wire ent_wr_valid0_i = fl[0];
   wire ent_wr_valid1_i = fl[1];
   wire ent_wr_dirty0_i = fl[2];
   wire ent_wr_dirty1_i = fl[3];

   tlb_fault_and_mode_logic i_tlb_fault_and_mode_logic (.*);
   pipeline_model i_pipeline_model (.clk_i, .acc_valid_o(acc_valid_i), .acc_store_o(acc_store_i),
      .acc_vaddr_o(acc_vaddr_i), .ent_wr_o(ent_wr_i), .ent_idx_o(ent_wr_idx_i), .ent_vpn2_o(ent_wr_vpn2_i),
      .ent_flags_o(fl));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic give_verdict();
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   // Sets the status bits and checks the decoded mode once it has settled.
   task automatic md(input logic e, input logic r, input logic [1:0] p, input logic d, input addr_mode_t m);
      @(posedge clk_i);
      #1;
      exception_level_bit_i = e;
      error_level_bit_i = r;
      privilege_field_i = p;
      debug_flag_i = d;
      #1;
      chk(addr_mode_o, m);
   endtask : md

   // One access and its one-cycle fault report.
   task automatic ac(input logic st, input logic [31:0] a, input fault_t f);
      i_pipeline_model.access(st, a);
      chk(fault_valid_o, f != FAULT_NONE);
      chk(fault_code_o, f);
   endtask : ac

   // Software write of the pointer, or of the layout when p is low.
   task automatic sw(input logic p, input logic [31:0] d);
      @(posedge clk_i);
      #1;
      ptr_wr_i = p;
      layout_wr_i = !p;
      ptr_wdata_i = d;
      layout_lsb_i = d[4:0];
      layout_len_i = d[12:8];
      @(posedge clk_i);
      #1;
      ptr_wr_i = 1'b0;
      layout_wr_i = 1'b0;
   endtask : sw

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // A hang is cut short well beyond the few hundred cycles the run needs.
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         give_verdict();
      end
   end

   initial begin
      {exception_level_bit_i, error_level_bit_i, debug_flag_i, user_style_access_i, ptr_wr_i} = '0;
      {extended_address_scheme_en_i, cache_or_bus_error_i, ent_wr_global_i, layout_wr_i} = '0;
      {privilege_field_i, layout_lsb_i, layout_len_i, ptr_wdata_i, ent_wr_asid_i, cur_asid_i} = '0;
      sys_rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      #1;
      sys_rst_i = 1'b0;
      chk(page_table_pointer_o, PTR_RST);
      chk(faulting_virtual_address_o, VADDR_RST);
      i_pipeline_model.boot_fill();
      md(1'b0, 1'b0, PRIV_KERNEL, 1'b0, MODE_KERNEL);
      md(1'b0, 1'b1, PRIV_USER, 1'b0, MODE_KERNEL);
      md(1'b1, 1'b0, PRIV_USER, 1'b0, MODE_KERNEL);
      md(1'b1, 1'b1, PRIV_SUPER, 1'b1, MODE_DEBUG);
      md(1'b0, 1'b0, PRIV_USER, 1'b0, MODE_USER);
      ac(1'b0, 32'hf000_0000, FAULT_LOAD_ADDR);
      ac(1'b0, 32'h8000_0000, FAULT_LOAD_ADDR);
      chk(entry_high_vpn2_o, 64'h0);
      ac(1'b1, 32'h8000_0004, FAULT_STORE_ADDR);
      chk(faulting_virtual_address_o, 32'h8000_0004);
      ac(1'b0, 32'h0000_2000, FAULT_REFILL);
      chk(entry_high_vpn2_o, 19'h0_0001);
      chk(page_table_pointer_o, 32'h0000_0010);
      extended_address_scheme_en_i = 1'b1;
      ac(1'b0, 32'ha000_0000, FAULT_REFILL);
      extended_address_scheme_en_i = 1'b0;
      md(1'b0, 1'b0, PRIV_SUPER, 1'b0, MODE_SUPER);
      ac(1'b0, 32'hc000_0000, FAULT_REFILL);
      ac(1'b1, 32'he000_0000, FAULT_STORE_ADDR);
      md(1'b0, 1'b0, PRIV_KERNEL, 1'b0, MODE_KERNEL);
      {extended_address_scheme_en_i, user_style_access_i} = 2'b11;
      ac(1'b0, 32'hd000_0000, FAULT_LOAD_ADDR);
      chk(ext_kernel_seg_o, 1'b1);
      {extended_address_scheme_en_i, user_style_access_i} = 2'b00;
      md(1'b1, 1'b0, PRIV_KERNEL, 1'b0, MODE_KERNEL);
      ac(1'b0, 32'h0000_4000, FAULT_REFILL);
      chk(general_vector_o, 1'b1);
      md(1'b0, 1'b0, PRIV_KERNEL, 1'b0, MODE_KERNEL);
      ac(1'b1, 32'h0000_4000, FAULT_REFILL);
      chk(general_vector_o, 1'b0);
      md(1'b0, 1'b0, PRIV_USER, 1'b0, MODE_USER);
      cache_or_bus_error_i = 1'b1;
      i_pipeline_model.access(1'b0, 32'h0000_6000);
      cache_or_bus_error_i = 1'b0;
      chk(faulting_virtual_address_o, 32'h0000_4000);
      i_pipeline_model.write_entry(6'd0, 19'h0_0010, 4'b0010);
      chk(dup_purged_o, 64'h0);
      ac(1'b0, 32'h0002_0000, FAULT_LOAD_INVALID);
      ac(1'b1, 32'h0002_0000, FAULT_STORE_INVALID);
      ac(1'b1, 32'h0002_1000, FAULT_MODIFIED);
      ac(1'b0, 32'h0002_1000, FAULT_NONE);
      i_pipeline_model.write_entry(6'd5, 19'h0_0010, 4'b1111);
      chk(dup_purged_o, 64'h1);
      ac(1'b1, 32'h0002_1000, FAULT_NONE);
      ac(1'b1, 32'h0002_0000, FAULT_NONE);
      sw(1'b1, 32'hffff_ffff);
      chk(page_table_pointer_o, 32'hff80_010f);
      sw(1'b0, 32'h0000_1308);
      ac(1'b0, 32'h0004_0000, FAULT_REFILL);
      chk(page_table_pointer_o & 32'hffff_ff00, 32'hf800_2000);
      give_verdict();
   end
endmodule : tlb_fault_and_mode_logic_tb_top

bind tlb_fault_and_mode_logic tlb_fault_checker i_tlb_fault_checker (.*);
